// ### cssc_top.sv
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
// Operation
// - high-speed oscillator self-starts at 8 MHz
// - cpu boots on internal high-speed clock
// - mode register bit stops high-speed oscillator
// - low-speed clock feeds only wdt, timer, lcd
// - option permits software low-speed stop
// - low-speed self-starts at 240 kHz, drives wdt
// - prescaler divides main clock for cpu
// - provide main, sub, low, cpu, peripheral clocks
// - low-threshold mode releases at low level
// - dual mode releases at high level
// - fast rise adds stabilization wait
// - settle status or select-wait gates crystal use
// - external clock needs no settle wait
// - stop halts high-speed sources
// - only idle sources may be stopped
// - settle select resets 05h, bad codes refused
// - settle status clears, sets in order, sticky
module cssc_top
   import cssc_pkg::*;
#(
   parameter int WIN_CYC  = POC_WIN_CYC,
   parameter int STAB_CYC = POC_STAB_CYC
) (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   input  wire cssc_opt_t   opt,
   input  wire logic        vdd_low_ok,
   input  wire logic        vdd_high_ok,
   input  wire logic        stop_req,
   input  wire logic        stop_wake,
   input  wire logic        main_xtal_tick,
   input  wire logic        ext_main_clk_in,
   input  wire logic        sub_xtal_tick,
   output cssc_clk_t        clk_out,
   output logic             poweron_clear,
   output logic             int_hs_osc_en,
   output logic             int_ls_osc_en,
   output logic             main_osc_en,
   output logic             sub_osc_en,
   output cssc_src_t        cpu_src,
   output logic             stop_mode
);
   logic        aw_rdy_r, ar_rdy_r, bvalid_r, rvalid_r;
   logic [1:0]  bresp_r, rresp_r;
   logic [31:0] rdata_r;
   logic        hs_stop_r, ls_stop_r, ext_sel_r, sub_pin_r, halt_r, stop_r;
   logic [2:0]  ssel_r, div_r;
   logic [4:0]  sst_r;
   logic [16:0] cnt_r;
   logic [7:0]  sub_cnt_r;
   logic [4:0]  hs_div_r;
   logic [9:0]  ls_div_r;
   logic [3:0]  pre_r;
   logic [20:0] poc_cnt_r;
   cssc_poc_t   poc_st_r, poc_nxt;
   cssc_src_t   src_r;
   cssc_clk_t   clk_r, clk_nxt;
   logic        hs_en_r, ls_en_r, mo_en_r, clr_r;

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   wire         wr_go   = awvalid && wvalid && !aw_rdy_r && !bvalid_r;
   wire         rd_go   = arvalid && !ar_rdy_r && !rvalid_r;
   wire         wr_en   = aw_rdy_r && wstrb[0];
   wire [7:0]   wd      = wdata[7:0];
   wire         w_iom   = wr_en && awaddr == A_IOM;
   wire         w_oms   = wr_en && awaddr == A_OMS;
   wire         w_halt  = wr_en && awaddr == A_HALT;
   wire         w_ssel  = wr_en && awaddr == A_SSEL;
   wire         w_csel  = wr_en && awaddr == A_CSEL;
   wire         aw_hit  = awaddr inside {A_IOM, A_OMS, A_HALT, A_SST, A_SSEL, A_CSEL};
   wire         ar_hit  = araddr inside {A_IOM, A_OMS, A_HALT, A_SST, A_SSEL, A_CSEL};
   wire [2:0]   w_div   = wd[CSEL_DIV +: 3];
   wire [31:0]  r_iom   = (32'(ls_stop_r) << IOM_LS) | (32'(hs_stop_r) << IOM_HS);
   wire [31:0]  r_oms   = (32'(ext_sel_r) << OMS_EXT) | (32'(sub_pin_r) << OMS_SUB);
   wire [31:0]  r_csel  = (32'(div_r) << CSEL_DIV) | (32'(src_r == SRC_SUB) << CSEL_SUB)
                        | (32'(src_r == SRC_MAIN) << CSEL_MAIN);
   wire [31:0]  rd_val  = araddr == A_IOM  ? r_iom :
                          araddr == A_OMS  ? r_oms :
                          araddr == A_HALT ? 32'(halt_r) << HALT_BIT :
                          araddr == A_SST  ? 32'(sst_r) :
                          araddr == A_SSEL ? 32'(ssel_r) :
                          araddr == A_CSEL ? r_csel : 32'h0;

   // ----------------------------------------
   // source state
   // ----------------------------------------
   wire         poc_run  = poc_st_r == POC_RUN;
   wire         hs_run   = poc_run && !hs_stop_r && !stop_r;
   // option gates the software stop
   // stop permission
   wire         ls_run   = poc_run && !(opt.ls_stop_ok && ls_stop_r);
   wire         main_run = poc_run && !halt_r && !stop_r;
   wire         sub_run  = poc_run && sub_pin_r;
   wire [2:0]   sidx     = ssel_r - SSEL_MIN;
   wire         settled  = cnt_r >= (17'h1 << SETTLE_EXP[sidx]);
   wire         main_rdy = main_run && (ext_sel_r || settled);
   wire         sub_rdy  = sub_run && sub_cnt_r == 8'(SUB_SETTLE_TICKS);
   wire         sst_clr  = stop_r || halt_r;
   wire         hs_tick  = hs_run && hs_div_r == 5'(HS_DIV - 1);
   wire         ls_tick  = ls_run && ls_div_r == 10'(LS_DIV - 1);
   wire         hx_tick  = main_run && (ext_sel_r ? ext_main_clk_in : main_xtal_tick);
   wire         sub_tick = sub_run && sub_xtal_tick;
   wire         on_main  = src_r == SRC_MAIN;
   wire         ms_tick  = on_main ? hx_tick : hs_tick;
   wire [3:0]   pmask    = 4'((5'h1 << div_r) - 5'h1);
   // cpu on main crystal waits for select time after wake
   wire         cpu_hold = !poc_run || stop_r || (on_main && !main_rdy);
   wire         pre_tick = ms_tick && (pre_r & pmask) == pmask;

   // ----------------------------------------
   // axi4-lite slave
   // ----------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         aw_rdy_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r  <= RESP_OK;
      end else begin
         aw_rdy_r <= wr_go;
         if (aw_rdy_r) begin
            bvalid_r <= 1'b1;
            bresp_r  <= aw_hit ? RESP_OK : RESP_ERR;
         end else if (bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ar_rdy_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0;
         rresp_r  <= RESP_OK;
      end else begin
         ar_rdy_r <= rd_go;
         if (ar_rdy_r) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_val;
            rresp_r  <= ar_hit ? RESP_OK : RESP_ERR;
         end else if (rready) begin
            rvalid_r <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // control registers
   // ----------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         hs_stop_r <= 1'b0;
         ls_stop_r <= 1'b0;
         ext_sel_r <= 1'b0;
         sub_pin_r <= 1'b0;
         halt_r    <= 1'b1;
         ssel_r    <= SSEL_RST;
         div_r     <= DIV_RST;
      end else begin
         if (w_iom) begin
            hs_stop_r <= wd[IOM_HS] && src_r != SRC_IHS;
            ls_stop_r <= wd[IOM_LS];
         end
         if (w_oms && (wd[OMS_SUB] || src_r != SRC_SUB))
            sub_pin_r <= wd[OMS_SUB];
         // pin mode is frozen while the crystal runs
         if (w_oms && halt_r)
            ext_sel_r <= wd[OMS_EXT];
         if (w_halt && (!wd[HALT_BIT] || !on_main))
            halt_r <= wd[HALT_BIT];
         if (w_ssel && wd[2:0] >= SSEL_MIN && wd[2:0] <= SSEL_RST)
            ssel_r <= wd[2:0];
         if (w_csel && w_div <= DIV_MAX)
            div_r <= w_div;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         src_r <= SRC_IHS;
      end else if (w_csel) begin
         if (wd[CSEL_SUB] && sub_rdy)
            src_r <= SRC_SUB;
         else if (wd[CSEL_MAIN] && !wd[CSEL_SUB] && main_rdy)
            src_r <= SRC_MAIN;
         else if (!wd[CSEL_MAIN] && !wd[CSEL_SUB] && hs_run)
            src_r <= SRC_IHS;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         stop_r <= 1'b0;
      else if (stop_req)
         stop_r <= 1'b1;
      else if (stop_wake)
         stop_r <= 1'b0;
   end

   // ----------------------------------------
   // settle counters
   // ----------------------------------------
   // counter stops at selected limit
   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         cnt_r <= 17'h0;
      else if (sst_clr)
         cnt_r <= 17'h0;
      else if (hx_tick && !ext_sel_r && !settled)
         cnt_r <= cnt_r + 17'h1;
   end

   // stages set shortest first, bit 4 first
   for (genvar i = 0; i < SST_N; i++) begin : g_sst
      always_ff @(posedge clk or posedge reset) begin
         if (reset)
            sst_r[SST_N - 1 - i] <= 1'b0;
         else if (sst_clr)
            sst_r[SST_N - 1 - i] <= 1'b0;
         else if (cnt_r >= (17'h1 << SETTLE_EXP[i]))
            sst_r[SST_N - 1 - i] <= 1'b1;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         sub_cnt_r <= 8'h0;
      else if (!sub_run)
         sub_cnt_r <= 8'h0;
      else if (sub_tick && !sub_rdy)
         sub_cnt_r <= sub_cnt_r + 8'h1;
   end

   // ----------------------------------------
   // dividers and prescaler
   // ----------------------------------------
   // free-running oscillator models
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         hs_div_r <= 5'h0;
         ls_div_r <= 10'h0;
      end else begin
         hs_div_r <= (!hs_run || hs_tick) ? 5'h0 : hs_div_r + 5'h1;
         ls_div_r <= (!ls_run || ls_tick) ? 10'h0 : ls_div_r + 10'h1;
      end
   end

   // divide by two to the div_r
   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         pre_r <= 4'h0;
      else if (ms_tick)
         pre_r <= pre_r + 4'h1;
   end

   // clock tree, low-speed never to cpu
   always_comb begin
      clk_nxt          = '0;
      clk_nxt.main_sys = ms_tick;
      clk_nxt.periph   = ms_tick;
      clk_nxt.sub      = sub_tick;
      clk_nxt.ls       = ls_tick;
      clk_nxt.wdt      = ls_tick && opt.wdt_en;
      clk_nxt.tmh1     = ls_tick;
      clk_nxt.lcd      = ls_tick;
      clk_nxt.cpu      = !cpu_hold && (src_r == SRC_SUB ? sub_tick : pre_tick);
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         clk_r   <= '0;
         hs_en_r <= 1'b0;
         ls_en_r <= 1'b0;
         mo_en_r <= 1'b0;
      end else begin
         clk_r   <= clk_nxt;
         hs_en_r <= hs_run;
         ls_en_r <= ls_run;
         mo_en_r <= main_run;
      end
   end

   // ----------------------------------------
   // power-on clear
   // ----------------------------------------
   // release sequencing
   always_comb begin
      poc_nxt = poc_st_r;
      unique case (poc_st_r)
         POC_HOLD: if (vdd_low_ok) poc_nxt = opt.poc_mode ? POC_RISE : POC_RUN;
         POC_RISE: if (!vdd_low_ok) poc_nxt = POC_HOLD;
                   else if (vdd_high_ok) poc_nxt = poc_cnt_r < 21'(WIN_CYC) ? POC_WAIT : POC_RUN;
         POC_WAIT: if (poc_cnt_r >= 21'(STAB_CYC - 1)) poc_nxt = POC_RUN;
         POC_RUN:  if (!vdd_low_ok) poc_nxt = POC_HOLD;
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         poc_st_r  <= POC_HOLD;
         poc_cnt_r <= 21'h0;
         clr_r     <= 1'b1;
      end else begin
         poc_st_r  <= poc_nxt;
         // flop copy of the decode, same timing as the state
         clr_r     <= poc_nxt != POC_RUN;
         poc_cnt_r <= poc_st_r == POC_HOLD ? 21'h0 : poc_cnt_r + 21'(poc_st_r != POC_RUN);
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign awready       = aw_rdy_r;
   assign wready        = aw_rdy_r;
   assign bvalid        = bvalid_r;
   assign bresp         = bresp_r;
   assign arready       = ar_rdy_r;
   assign rvalid        = rvalid_r;
   assign rdata         = rdata_r;
   assign rresp         = rresp_r;
   assign clk_out       = clk_r;
   assign poweron_clear = clr_r;
   assign int_hs_osc_en = hs_en_r;
   assign int_ls_osc_en = ls_en_r;
   assign main_osc_en   = mo_en_r;
   assign sub_osc_en    = sub_pin_r;
   assign cpu_src       = src_r;
   assign stop_mode     = stop_r;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_low_up;
      poc_st_r == POC_HOLD && !opt.poc_mode && vdd_low_ok;
   endsequence
   sequence s_fast_rise;
      poc_st_r == POC_RISE && vdd_low_ok && vdd_high_ok && poc_cnt_r < 21'(WIN_CYC);
   endsequence

   hs_start_a: assert property (hs_run |=> int_hs_osc_en)
      else $error("high-speed oscillator not running");
   src_write_a: assert property (src_r != $past(src_r) |-> $past(w_csel))
      else $error("cpu source changed without write");
   ls_perm_a: assert property (poc_run && !opt.ls_stop_ok |=> int_ls_osc_en)
      else $error("low-speed stopped without permission");
   wdt_feed_a: assert property (clk_out.wdt |-> $past(opt.wdt_en) && clk_out.ls)
      else $error("wdt tick without low-speed tick");
   cpu_tick_a: assert property (clk_nxt.cpu && src_r != SRC_SUB |-> ms_tick ##1 clk_out.main_sys)
      else $error("cpu tick not from main clock");
   stop_halt_a: assert property (stop_r |=> !int_hs_osc_en && !main_osc_en)
      else $error("oscillator running in stop");
   idle_stop_a: assert property (!(src_r == SRC_IHS && hs_stop_r) && !(on_main && halt_r))
      else $error("cpu source stopped");
   sst_clear_a: assert property (sst_clr |=> sst_r == SST_RST)
      else $error("settle status not cleared");
   sst_order_a: assert property (((sst_r << 1) & ~sst_r) == 5'h00)
      else $error("settle status out of order");
   ssel_code_a: assert property (ssel_r >= SSEL_MIN && ssel_r <= SSEL_RST)
      else $error("settle select holds prohibited code");
   poc_low_a: assert property (s_low_up |=> !poweron_clear)
      else $error("low-threshold release missing");
   poc_wait_a: assert property (s_fast_rise |=> poc_st_r == POC_WAIT ##1 poweron_clear)
      else $error("stabilization wait not inserted");
endmodule // cssc_top

// ### cssc_pkg.sv
package cssc_pkg;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_MHZ = 200;
   localparam int CLK_KHZ = CLK_MHZ * 1000;
   localparam int HS_KHZ  = 8000;
   localparam int LS_KHZ  = 240;
   localparam int HS_DIV  = CLK_KHZ / HS_KHZ;
   localparam int LS_DIV  = CLK_KHZ / LS_KHZ;
   localparam int POC_WIN_NS  = 1930000;
   localparam int POC_STAB_NS = 5390000;
   localparam int POC_WIN_CYC  = POC_WIN_NS / 1000 * CLK_MHZ;
   localparam int POC_STAB_CYC = POC_STAB_NS / 1000 * CLK_MHZ;
   localparam int SUB_SETTLE_TICKS = 64;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [7:0] A_IOM  = 8'h00;
   localparam logic [7:0] A_OMS  = 8'h04;
   localparam logic [7:0] A_HALT = 8'h08;
   localparam logic [7:0] A_SST  = 8'h0c;
   localparam logic [7:0] A_SSEL = 8'h10;
   localparam logic [7:0] A_CSEL = 8'h14;
   localparam int IOM_HS   = 0;
   localparam int IOM_LS   = 1;
   localparam int OMS_SUB  = 4;
   localparam int OMS_EXT  = 6;
   localparam int HALT_BIT = 7;
   localparam int CSEL_MAIN = 0;
   localparam int CSEL_SUB  = 1;
   localparam int CSEL_DIV  = 4;
   localparam logic [2:0] SSEL_RST = 3'h5;
   localparam logic [2:0] SSEL_MIN = 3'h1;
   localparam logic [2:0] DIV_RST  = 3'h1;
   localparam logic [2:0] DIV_MAX  = 3'h4;
   localparam logic [4:0] SST_RST  = 5'h00;
   localparam int SST_N = 5;
   // settle stages, shortest first
   localparam int SETTLE_EXP [SST_N] = '{11, 13, 14, 15, 16};
   localparam logic [1:0] RESP_OK  = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;
   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0] {SRC_IHS, SRC_MAIN, SRC_SUB} cssc_src_t;
   typedef enum logic [1:0] {POC_HOLD, POC_RISE, POC_WAIT, POC_RUN} cssc_poc_t;
   typedef struct packed {
      logic poc_mode;
      logic ls_stop_ok;
      logic wdt_en;
   } cssc_opt_t;
   typedef struct packed {
      logic main_sys;
      logic sub;
      logic ls;
      logic cpu;
      logic periph;
      logic wdt;
      logic tmh1;
      logic lcd;
   } cssc_clk_t;
endpackage

// ### cssc_tb.sv
`timescale 1ns/1ps
module tb;
   import cssc_pkg::*;
   // ----------------------------------------
   // setup
   // ----------------------------------------
   // short power-on windows keep the run brief
   localparam int WIN   = 20;
   localparam int STAB  = 60;
   localparam int K_CPU = 4;
   localparam int K_LS  = 5;
   localparam int K_WDT = 2;
   localparam int K_MS  = 7;
   localparam int K_SUB = 6;
   localparam int K_PER = 3;
   localparam int K_TMH = 1;
   localparam int K_LCD = 0;
   typedef struct {logic [31:0] d; logic [1:0] r;} cssc_exp_t;
   logic        clk, reset, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, tick_n;
   logic        vdd_low_ok, vdd_high_ok, stop_req, stop_wake;
   logic        main_xtal_tick, ext_main_clk_in, sub_xtal_tick;
   logic        poweron_clear, int_hs_osc_en, int_ls_osc_en, main_osc_en, sub_osc_en, stop_mode;
   logic        xt_on, ext_on, sub_on;
   cssc_opt_t   opt;
   cssc_clk_t   clk_out;
   cssc_src_t   cpu_src;
   cssc_exp_t   wq [$];
   cssc_exp_t   rq [$];
   cssc_exp_t   ex_w, ex_r;
   int          fails, cmp_count;
   int          pc [8];
   integer      seed;

   cssc_top #(.WIN_CYC(WIN), .STAB_CYC(STAB)) i_cssc_top (
      .clk(clk), .reset(reset), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .opt(opt),
      .vdd_low_ok(vdd_low_ok), .vdd_high_ok(vdd_high_ok), .stop_req(stop_req),
      .stop_wake(stop_wake), .main_xtal_tick(main_xtal_tick), .ext_main_clk_in(ext_main_clk_in),
      .sub_xtal_tick(sub_xtal_tick), .clk_out(clk_out), .poweron_clear(poweron_clear),
      .int_hs_osc_en(int_hs_osc_en), .int_ls_osc_en(int_ls_osc_en), .main_osc_en(main_osc_en),
      .sub_osc_en(sub_osc_en), .cpu_src(cpu_src), .stop_mode(stop_mode));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", what, e, g);
         fails++;
      end
   endtask

   task automatic near(input string what, input int e, input int g, input int tol);
      chk(what, e, (g >= e - tol && g <= e + tol) ? e : g);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OK);
      logic [31:0] r;
      int          n;
      r = $random(seed);
      wq.push_back('{32'h0, er});
      awaddr  <= a;
      wdata   <= {r[31:8], d};
      wstrb   <= 4'hf;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (!(awready === 1'b1 && wready === 1'b1) && n < 100);
      awvalid <= 1'b0;
      wvalid  <= 1'b0;
      do begin
         @(posedge clk);
         n++;
      end while (bvalid !== 1'b1 && n < 100);
      bready <= 1'b0;
      chk("write wait", 0, n >= 100);
      @(posedge clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OK);
      int n;
      rq.push_back('{e, er});
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (arready !== 1'b1 && n < 100);
      arvalid <= 1'b0;
      do begin
         @(posedge clk);
         n++;
      end while (rvalid !== 1'b1 && n < 100);
      rready <= 1'b0;
      chk("read wait", 0, n >= 100);
      @(posedge clk);
   endtask

   task automatic pulses(input int cyc);
      pc = '{default: 0};
      repeat (cyc) begin
         @(posedge clk);
         for (int k = 0; k < 8; k++) begin
            pc[k] += clk_out[k];
         end
      end
   endtask

   task automatic until_clear(output int n);
      n = 0;
      while (poweron_clear !== 1'b0 && n < 1000) begin
         @(posedge clk);
         n++;
      end
   endtask

   task automatic done(input string s);
      $display("test %s done", s);
   endtask

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // ----------------------------------------
   // response monitor
   // ----------------------------------------
   always @(posedge clk) begin
      if (bvalid === 1'b1 && bready === 1'b1 && wq.size() > 0) begin
         ex_w = wq.pop_front();
         chk("bresp", ex_w.r, bresp);
      end
      if (rvalid === 1'b1 && rready === 1'b1 && rq.size() > 0) begin
         ex_r = rq.pop_front();
         chk("rdata", ex_r.d, rdata);
         chk("rresp", ex_r.r, rresp);
      end
   end

   // crystal models tick only while enabled by the sequence
   always @(posedge clk) begin
      tick_n          <= tick_n + 2'h1;
      main_xtal_tick  <= xt_on;
      ext_main_clk_in <= ext_on & tick_n[0];
      sub_xtal_tick   <= sub_on & (tick_n == 2'h0);
   end

   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      logic [2:0] sel;
      int         n;
      seed = 32'h87f9;
      {reset, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
      {awaddr, araddr, wdata, wstrb, tick_n} = '0;
      {stop_req, stop_wake, xt_on, ext_on, sub_on} = '0;
      opt = '{poc_mode: 1'b0, ls_stop_ok: 1'b0, wdt_en: 1'b1};
      vdd_low_ok = 1'b1;
      vdd_high_ok = 1'b1;
      sel = SSEL_RST;
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      repeat (3) @(posedge clk);
      chk("cpu_src", SRC_IHS, cpu_src);
      chk("hs osc", 1, int_hs_osc_en);
      chk("ls osc", 1, int_ls_osc_en);
      chk("poc", 0, poweron_clear);
      rd(A_IOM, 32'h0);
      rd(A_OMS, 32'h0);
      rd(A_HALT, 32'h80);
      rd(A_SST, 32'h0);
      rd(A_SSEL, 32'h5);
      rd(A_CSEL, 32'h10);
      rd(8'h40, 32'h0, RESP_ERR);
      wr(8'h40, 8'h00, RESP_ERR);
      pulses(10 * LS_DIV);
      near("ls ticks", 10, pc[K_LS], 1);
      near("wdt ticks", 10, pc[K_WDT], 1);
      near("tmh1 ticks", 10, pc[K_TMH], 1);
      near("lcd ticks", 10, pc[K_LCD], 1);
      near("main sys ticks", 10 * LS_DIV / HS_DIV, pc[K_MS], 1);
      near("periph ticks", 10 * LS_DIV / HS_DIV, pc[K_PER], 1);
      chk("cpu ticks", 1, pc[K_CPU] > 0);
      // watchdog gate off: low-speed keeps running, wdt goes quiet
      opt.wdt_en <= 1'b0;
      @(posedge clk);
      pulses(2 * LS_DIV);
      chk("wdt off", 0, pc[K_WDT]);
      chk("ls on", 1, pc[K_LS] > 0);
      opt.wdt_en <= 1'b1;
      done("reset");
      wr(A_IOM, 8'h01);
      chk("hs kept", 1, int_hs_osc_en);
      rd(A_IOM, 32'h0);
      wr(A_IOM, 8'h02);
      chk("ls kept", 1, int_ls_osc_en);
      opt.ls_stop_ok <= 1'b1;
      wr(A_IOM, 8'h02);
      chk("ls stop", 0, int_ls_osc_en);
      wr(A_IOM, 8'h00);
      chk("ls back", 1, int_ls_osc_en);
      for (int c = 0; c < 8; c++) begin
         wr(A_SSEL, c[7:0]);
         sel = (c >= 1 && c <= 5) ? c[2:0] : sel;
         rd(A_SSEL, {29'h0, sel});
      end
      wr(A_SSEL, 8'h02);
      done("stop and select");
      xt_on <= 1'b1;
      wr(A_HALT, 8'h00);
      chk("main osc", 1, main_osc_en);
      wr(A_CSEL, 8'h11);
      chk("early switch", SRC_IHS, cpu_src);
      repeat (2200) @(posedge clk);
      rd(A_SST, 32'h10);
      repeat (6200) @(posedge clk);
      rd(A_SST, 32'h18);
      wr(A_CSEL, 8'h11);
      chk("main switch", SRC_MAIN, cpu_src);
      for (int d = 0; d < 6; d++) begin
         wr(A_CSEL, {1'b0, d[2:0], 4'h1});
         pulses(128);
         near("cpu div", (d < 5) ? 128 >> d : 8, pc[K_CPU], 1);
      end
      rd(A_CSEL, 32'h41);
      wr(A_HALT, 8'h80);
      chk("halt kept", 1, main_osc_en);
      stop_req <= 1'b1;
      @(posedge clk);
      stop_req <= 1'b0;
      repeat (3) @(posedge clk);
      chk("stop mode", 1, stop_mode);
      chk("stop hs", 0, int_hs_osc_en);
      chk("stop main", 0, main_osc_en);
      stop_wake <= 1'b1;
      @(posedge clk);
      stop_wake <= 1'b0;
      rd(A_SST, 32'h0);
      pulses(7900);
      chk("wake hold", 0, pc[K_CPU]);
      pulses(600);
      chk("wake run", 1, pc[K_CPU] > 0);
      done("main crystal");
      wr(A_CSEL, 8'h10);
      chk("to ihs", SRC_IHS, cpu_src);
      wr(A_HALT, 8'h80);
      chk("halted", 0, main_osc_en);
      xt_on <= 1'b0;
      ext_on <= 1'b1;
      wr(A_OMS, 8'h40);
      wr(A_HALT, 8'h00);
      wr(A_CSEL, 8'h11);
      chk("ext switch", SRC_MAIN, cpu_src);
      wr(A_CSEL, 8'h10);
      wr(A_HALT, 8'h80);
      done("external");
      // sub pin bit left clear until the sub crystal is wanted
      wr(A_OMS, 8'h10);
      chk("sub osc", 1, sub_osc_en);
      wr(A_CSEL, 8'h12);
      chk("sub early", SRC_IHS, cpu_src);
      sub_on <= 1'b1;
      repeat (300) @(posedge clk);
      wr(A_CSEL, 8'h12);
      chk("sub switch", SRC_SUB, cpu_src);
      pulses(400);
      near("sub ticks", 100, pc[K_SUB], 1);
      near("cpu on sub", 100, pc[K_CPU], 1);
      wr(A_OMS, 8'h00);
      rd(A_OMS, 32'h10);
      wr(A_IOM, 8'h01);
      chk("hs off", 0, int_hs_osc_en);
      wr(A_IOM, 8'h00);
      chk("hs on", 1, int_hs_osc_en);
      wr(A_CSEL, 8'h10);
      chk("sub back", SRC_IHS, cpu_src);
      done("sub");
      vdd_low_ok <= 1'b0;
      repeat (3) @(posedge clk);
      chk("poc low", 1, poweron_clear);
      vdd_low_ok <= 1'b1;
      until_clear(n);
      near("poc mode0", 1, n, 2);
      opt.poc_mode <= 1'b1;
      {vdd_low_ok, vdd_high_ok} <= 2'b00;
      reset <= 1'b1;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      repeat (3) @(posedge clk);
      vdd_low_ok <= 1'b1;
      repeat (5) @(posedge clk);
      vdd_high_ok <= 1'b1;
      until_clear(n);
      near("poc fast rise", STAB, n + 5, 3);
      {vdd_low_ok, vdd_high_ok} <= 2'b00;
      repeat (3) @(posedge clk);
      vdd_low_ok <= 1'b1;
      repeat (WIN + 10) @(posedge clk);
      chk("poc held", 1, poweron_clear);
      vdd_high_ok <= 1'b1;
      until_clear(n);
      near("poc slow rise", 1, n, 2);
      chk("poc cpu", SRC_IHS, cpu_src);
      done("power on");
      wrap_up();
   end

   initial begin
      #(5 * 60000);
      chk("watchdog", 0, 1);
      wrap_up();
   end
endmodule // tb
